// ### rtl/ebp_bus_port.sv
`timescale 1ns/1ps
`include "ebp_params.svh"

// Notes on behaviour
// - Bus clock runs free or gives one low-high pulse per visible access.
// - Clock disable, visibility and stretch bits choose the bus clock behaviour.
// - Low-byte strobe driven low means low data byte valid.
// - Low tag taken when pin low at bus clock fall, wide/emul-narrow, tagging on.
// - Direction pin is output in expanded modes with its enable set; input in peripheral mode.
// - Both interrupt pins input only; maskable pin always readable.
// - Maskable request level or edge sensitive; second input non-maskable.
// - Port K pins are general I/O when not assigned to bus functions.
// - Top port K pin selects emulation chip, next selects external data.
// - Registers decoded by offset bits only; upper address bits ignored.
// - Bus interface control register at its own offset, read and write.
// - Unused locations and bits read zero; writes to them do nothing.
module ebp_bus_port (
   // Clocks and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic link_clk,
   // Register port
   input wire logic [9:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // CPU side
   input wire ebp_pkg::ebp_acc_t acc,
   input wire logic tag_enable,
   input wire logic irq_edge_ack,
   output logic acc_busy,
   output logic maskable_irq,
   output logic nonmaskable_irq,
   output logic tag_low_hit,
   output logic tester_narrow,
   output logic tester_read,
   // Pins
   input wire logic [2:0] mode_strap,
   input wire logic [7:0] pe_in,
   output logic [7:0] pe_out,
   output logic [7:0] pe_oe_n,
   input wire logic [7:0] pk_in,
   output logic [7:0] pk_out,
   output logic [7:0] pk_oe_n
);

   // Read value of a general-purpose pin group
   function automatic logic [7:0] gpio_read(input logic [7:0] dir, input logic [7:0] dat,
                                            input logic [7:0] pin);
      gpio_read = (dir & dat) | (~dir & pin);
   endfunction

   // Reset release; strap flops run on raw reset so they settle before capture
   logic rst_s1, rst_sync_n;
   logic [2:0] strap_s1, strap_s2;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1 <= 1'b0;
         rst_sync_n <= 1'b0;
         strap_s1 <= 3'h0;
         strap_s2 <= 3'h0;
      end else begin
         rst_s1 <= 1'b1;
         rst_sync_n <= rst_s1;
         strap_s1 <= mode_strap;
         strap_s2 <= strap_s1;
      end
   end

   // Pin synchronisers in the system domain
   logic [7:0] pe_s1, pe_s2, pk_s1, pk_s2;
   logic irq_s3;
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pe_s1 <= `EBP_RST_IDLE_HI;
         pe_s2 <= `EBP_RST_IDLE_HI;
         pk_s1 <= `EBP_RST_BYTE;
         pk_s2 <= `EBP_RST_BYTE;
         irq_s3 <= 1'b1;
      end else begin
         pe_s1 <= pe_in;
         pe_s2 <= pe_s1;
         pk_s1 <= pk_in;
         pk_s2 <= pk_s1;
         irq_s3 <= pe_s2[`EBP_PE_IRQ];
      end
   end

   // Link domain: tester size and direction pins, with its own reset release
   logic lk_rst_s1, lk_rst_n;
   logic [1:0] lk_s1, lk_s2, lk_smp_r;
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         lk_rst_s1 <= 1'b0;
         lk_rst_n <= 1'b0;
      end else begin
         lk_rst_s1 <= 1'b1;
         lk_rst_n <= lk_rst_s1;
      end
   end
   always_ff @(posedge link_clk or negedge lk_rst_n) begin
      if (!lk_rst_n) begin
         lk_s1 <= 2'h3;
         lk_s2 <= 2'h3;
         lk_smp_r <= 2'h3;
      end else begin
         lk_s1 <= pe_in[`EBP_PE_LOW_BYTE_STROBE_N:`EBP_PE_RW];
         lk_s2 <= lk_s1;
         lk_smp_r <= lk_s2;
      end
   end

   // Tester levels cross back as slow levels through two flops
   logic [1:0] tst_s1, tst_s2;
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         tst_s1 <= 2'h3;
         tst_s2 <= 2'h3;
      end else begin
         tst_s1 <= lk_smp_r;
         tst_s2 <= tst_s1;
      end
   end

   // Register storage
   logic [7:0] pa_dat_r, pb_dat_r, pa_dir_r, pb_dir_r, pe_dat_r, pe_dir_r;
   logic [7:0] assign_r, mode_r, pull_r, rdrv_r, bic_r, irqc_r, pk_dat_r, pk_dir_r;
   logic strap_done_r;

   // Offset decode ignores the relocated upper address bits
   wire [`EBP_OFS_W-1:0] ofs = reg_addr[`EBP_OFS_W-1:0];
   wire wr_pa = reg_wr && ofs == `EBP_OFS_PORT_A_DATA;
   wire wr_pb = reg_wr && ofs == `EBP_OFS_PORT_B_DATA;
   wire wr_pad = reg_wr && ofs == `EBP_OFS_PORT_A_DIR;
   wire wr_pbd = reg_wr && ofs == `EBP_OFS_PORT_B_DIR;
   wire wr_pe = reg_wr && ofs == `EBP_OFS_PORT_E_DATA;
   wire wr_ped = reg_wr && ofs == `EBP_OFS_PORT_E_DIR;
   wire wr_asg = reg_wr && ofs == `EBP_OFS_PORT_E_ASSIGN;
   wire wr_mode = reg_wr && ofs == `EBP_OFS_OP_MODE;
   wire wr_pull = reg_wr && ofs == `EBP_OFS_PULL_CTRL;
   wire wr_rdrv = reg_wr && ofs == `EBP_OFS_REDUCED_DRIVE;
   wire wr_bic = reg_wr && ofs == `EBP_OFS_BUS_IF_CTRL;
   wire wr_irqc = reg_wr && ofs == `EBP_OFS_IRQ_CTRL;
   wire wr_pk = reg_wr && ofs == `EBP_OFS_PORT_K_DATA;
   wire wr_pkd = reg_wr && ofs == `EBP_OFS_PORT_K_DIR;

   // Writes store only implemented bits
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pa_dat_r <= `EBP_RST_BYTE;
         pb_dat_r <= `EBP_RST_BYTE;
         pa_dir_r <= `EBP_RST_BYTE;
         pb_dir_r <= `EBP_RST_BYTE;
         pull_r <= `EBP_RST_BYTE;
         rdrv_r <= `EBP_RST_BYTE;
      end else begin
         if (wr_pa) pa_dat_r <= reg_wdata;
         if (wr_pb) pb_dat_r <= reg_wdata;
         if (wr_pad) pa_dir_r <= reg_wdata;
         if (wr_pbd) pb_dir_r <= reg_wdata;
         if (wr_pull) pull_r <= reg_wdata;
         if (wr_rdrv) rdrv_r <= reg_wdata;
      end
   end

   // Port E, K and control registers
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pe_dat_r <= `EBP_RST_BYTE;
         pe_dir_r <= `EBP_RST_BYTE;
         assign_r <= `EBP_RST_BYTE;
         bic_r <= `EBP_RST_BYTE;
         irqc_r <= `EBP_RST_BYTE;
         pk_dat_r <= `EBP_RST_BYTE;
         pk_dir_r <= `EBP_RST_BYTE;
      end else begin
         if (wr_pe) pe_dat_r <= reg_wdata;
         if (wr_ped) pe_dir_r <= reg_wdata & `EBP_MASK_PORT_E_DIR;
         if (wr_asg) assign_r <= reg_wdata & `EBP_MASK_PORT_E_ASSIGN;
         if (wr_bic) bic_r <= reg_wdata & `EBP_MASK_BUS_IF_CTRL;
         if (wr_irqc) irqc_r <= reg_wdata & `EBP_MASK_IRQ_CTRL;
         if (wr_pk) pk_dat_r <= reg_wdata;
         if (wr_pkd) pk_dir_r <= reg_wdata;
      end
   end

   // Mode strap is caught once, on the first edge after release
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         mode_r <= `EBP_RST_BYTE;
         strap_done_r <= 1'b0;
      end else begin
         strap_done_r <= 1'b1;
         if (!strap_done_r) mode_r <= {strap_s2, 5'h00};
         else if (wr_mode) mode_r <= reg_wdata & `EBP_MASK_OP_MODE;
      end
   end

   // Mode decode
   wire [2:0] md = mode_r[`EBP_MODE_SEL_HI:`EBP_MODE_SEL_LO];
   wire md_periph = md == `EBP_MD_PERIPHERAL;
   wire md_single = md == `EBP_MD_SPECIAL_SINGLE || md == `EBP_MD_NORMAL_SINGLE;
   wire md_exp = !md_single && !md_periph;
   wire md_tag = md == `EBP_MD_NORMAL_WIDE || md == `EBP_MD_EMUL_WIDE
                 || md == `EBP_MD_EMUL_NARROW;
   wire clk_dis = assign_r[`EBP_ASSIGN_CLK_DIS];
   wire low_byte_strobe_n_en = assign_r[`EBP_ASSIGN_LOW_BYTE_STROBE_N_EN];
   wire rw_en = assign_r[`EBP_ASSIGN_RW_EN];
   wire vis_int = mode_r[`EBP_MODE_VIS];
   wire pk_fn = mode_r[`EBP_MODE_PORT_K_EN] && md_exp;
   wire stretch_on = bic_r[`EBP_BIC_STRETCH];

   // Bus clock sequencer
   ebp_pkg::ebp_state_t state_r, state_nxt;
   ebp_pkg::ebp_acc_t acc_r;
   logic [1:0] str_cnt_r;
   logic bclk_r;
   wire take = acc.valid && state_r == ebp_pkg::ST_IDLE;
   wire visible_r = !acc_r.internal || vis_int;
   wire str_done = str_cnt_r == 2'(`EBP_STRETCH_CYC - 1);
   wire need_str = stretch_on && acc_r.slow;

   // Next state: low phase, high phase, optional stretched high
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ebp_pkg::ST_IDLE: if (take) state_nxt = ebp_pkg::ST_LOW;
         ebp_pkg::ST_LOW: state_nxt = ebp_pkg::ST_HIGH;
         ebp_pkg::ST_HIGH: state_nxt = need_str ? ebp_pkg::ST_STRETCH : ebp_pkg::ST_IDLE;
         ebp_pkg::ST_STRETCH: if (str_done) state_nxt = ebp_pkg::ST_IDLE;
         default: state_nxt = ebp_pkg::ST_IDLE;
      endcase
   end

   // Held low when clock disable is set; else free running unless stretch is selected, then one pulse per visible access
   wire in_high = state_nxt == ebp_pkg::ST_HIGH || state_nxt == ebp_pkg::ST_STRETCH;
   wire bclk_nxt = clk_dis ? 1'b0 :
                   !stretch_on ? !bclk_r :
                   in_high && visible_r;
   wire bclk_fall = bclk_r && !bclk_nxt;

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state_r <= ebp_pkg::ST_IDLE;
         acc_r <= '0;
         str_cnt_r <= 2'h0;
         bclk_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (take) acc_r <= acc;
         str_cnt_r <= state_r == ebp_pkg::ST_STRETCH ? str_cnt_r + 2'h1 : 2'h0;
         bclk_r <= bclk_nxt;
      end
   end

   // Bus-phase pin values
   wire active = state_r != ebp_pkg::ST_IDLE && visible_r;
   wire low_byte_strobe_n_val = !(active && acc_r.low_byte);
   wire rw_val = !(active && acc_r.write);
   wire [7:0] pe_gpio_oe_n = ~pe_dir_r;

   // Port E pin function selection
   logic [7:0] pe_out_nxt, pe_oe_n_nxt;
   always_comb begin
      pe_out_nxt = pe_dat_r;
      pe_oe_n_nxt = pe_gpio_oe_n;
      if (md_exp && !clk_dis) begin
         pe_out_nxt[`EBP_PE_BCLK] = bclk_nxt;
         pe_oe_n_nxt[`EBP_PE_BCLK] = 1'b0;
      end
      if (md_periph) begin
         pe_oe_n_nxt[`EBP_PE_LOW_BYTE_STROBE_N] = 1'b1;
         pe_oe_n_nxt[`EBP_PE_RW] = 1'b1;
      end else begin
         if (md_exp && low_byte_strobe_n_en) begin
            pe_out_nxt[`EBP_PE_LOW_BYTE_STROBE_N] = low_byte_strobe_n_val;
            pe_oe_n_nxt[`EBP_PE_LOW_BYTE_STROBE_N] = 1'b0;
         end
         if (md_exp && rw_en) begin
            pe_out_nxt[`EBP_PE_RW] = rw_val;
            pe_oe_n_nxt[`EBP_PE_RW] = 1'b0;
         end
      end
      // Interrupt pins never drive
      pe_out_nxt[`EBP_PE_IRQ] = 1'b0;
      pe_out_nxt[`EBP_PE_NMI] = 1'b0;
      pe_oe_n_nxt[`EBP_PE_IRQ] = 1'b1;
      pe_oe_n_nxt[`EBP_PE_NMI] = 1'b1;
   end

   // Port K: chip selects and page address override general I/O
   logic [7:0] pk_out_nxt, pk_oe_n_nxt;
   always_comb begin
      pk_out_nxt = pk_dat_r;
      pk_oe_n_nxt = ~pk_dir_r;
      if (pk_fn) begin
         pk_out_nxt[`EBP_PK_EMUL] = !(active && acc_r.emul);
         pk_out_nxt[`EBP_PK_XDATA] = !(active && acc_r.ext_data);
         pk_out_nxt[5:0] = active ? acc_r.page : 6'h00;
         pk_oe_n_nxt = 8'h00;
      end
   end

   // Interrupt requests; an edge in the acknowledge cycle is kept
   logic irq_edge_r;
   wire irq_fall = irq_s3 && !pe_s2[`EBP_PE_IRQ];
   wire irq_edge_mode = irqc_r[`EBP_IRQ_EDGE];
   wire irq_nxt = irq_edge_mode ? irq_edge_r : !pe_s2[`EBP_PE_IRQ];
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         irq_edge_r <= 1'b0;
      end else begin
         irq_edge_r <= irq_fall || (irq_edge_r && !irq_edge_ack);
      end
   end

   // Register read mux; unmapped offsets read zero
   logic [7:0] rd_mux;
   wire [7:0] pe_rd = gpio_read(pe_dir_r, pe_dat_r, pe_s2);
   wire [7:0] pk_rd = gpio_read(pk_dir_r, pk_dat_r, pk_s2);
   always_comb begin
      case (ofs)
         `EBP_OFS_PORT_A_DATA: rd_mux = pa_dat_r;
         `EBP_OFS_PORT_B_DATA: rd_mux = pb_dat_r;
         `EBP_OFS_PORT_A_DIR: rd_mux = pa_dir_r;
         `EBP_OFS_PORT_B_DIR: rd_mux = pb_dir_r;
         `EBP_OFS_PORT_E_DATA: rd_mux = pe_rd;
         `EBP_OFS_PORT_E_DIR: rd_mux = pe_dir_r;
         `EBP_OFS_PORT_E_ASSIGN: rd_mux = assign_r;
         `EBP_OFS_OP_MODE: rd_mux = mode_r;
         `EBP_OFS_PULL_CTRL: rd_mux = pull_r;
         `EBP_OFS_REDUCED_DRIVE: rd_mux = rdrv_r;
         `EBP_OFS_BUS_IF_CTRL: rd_mux = bic_r;
         `EBP_OFS_IRQ_CTRL: rd_mux = irqc_r;
         `EBP_OFS_PORT_K_DATA: rd_mux = pk_rd;
         `EBP_OFS_PORT_K_DIR: rd_mux = pk_dir_r;
         default: rd_mux = 8'h00;
      endcase
   end

   // Output flops
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         reg_rdata <= 8'h00;
         pe_out <= `EBP_RST_BYTE;
         pe_oe_n <= `EBP_RST_IDLE_HI;
         pk_out <= `EBP_RST_BYTE;
         pk_oe_n <= `EBP_RST_IDLE_HI;
         acc_busy <= 1'b0;
         maskable_irq <= 1'b0;
         nonmaskable_irq <= 1'b0;
         tag_low_hit <= 1'b0;
         tester_narrow <= 1'b0;
         tester_read <= 1'b0;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 8'h00;
         pe_out <= pe_out_nxt;
         pe_oe_n <= pe_oe_n_nxt;
         pk_out <= pk_out_nxt;
         pk_oe_n <= pk_oe_n_nxt;
         acc_busy <= state_nxt != ebp_pkg::ST_IDLE;
         maskable_irq <= irqc_r[`EBP_IRQ_EN] && irq_nxt;
         nonmaskable_irq <= !pe_s2[`EBP_PE_NMI];
         tag_low_hit <= bclk_fall && tag_enable && low_byte_strobe_n_en && md_tag
                        && !pe_s2[`EBP_PE_LOW_BYTE_STROBE_N];
         tester_narrow <= md_periph && tst_s2[1];
         tester_read <= md_periph && tst_s2[0];
      end
   end

endmodule

// ### rtl/ebp_params.svh
`ifndef EBP_PARAMS_SVH
`define EBP_PARAMS_SVH

// Register offsets, low six address bits only
`define EBP_OFS_W 6
`define EBP_OFS_PORT_A_DATA 6'h00
`define EBP_OFS_PORT_B_DATA 6'h01
`define EBP_OFS_PORT_A_DIR 6'h02
`define EBP_OFS_PORT_B_DIR 6'h03
`define EBP_OFS_PORT_E_DATA 6'h08
`define EBP_OFS_PORT_E_DIR 6'h09
`define EBP_OFS_PORT_E_ASSIGN 6'h0a
`define EBP_OFS_OP_MODE 6'h0b
`define EBP_OFS_PULL_CTRL 6'h0c
`define EBP_OFS_REDUCED_DRIVE 6'h0d
`define EBP_OFS_BUS_IF_CTRL 6'h0e
`define EBP_OFS_IRQ_CTRL 6'h1e
`define EBP_OFS_PORT_K_DATA 6'h32
`define EBP_OFS_PORT_K_DIR 6'h33

// Reset values
`define EBP_RST_BYTE 8'h00
`define EBP_RST_IDLE_HI 8'hff

// Implemented-bit masks; other bits read zero
`define EBP_MASK_PORT_E_DIR 8'hfc
`define EBP_MASK_PORT_E_ASSIGN 8'h1c
`define EBP_MASK_OP_MODE 8'he9
`define EBP_MASK_BUS_IF_CTRL 8'h01
`define EBP_MASK_IRQ_CTRL 8'hc0

// Field positions
`define EBP_ASSIGN_CLK_DIS 4
`define EBP_ASSIGN_LOW_BYTE_STROBE_N_EN 3
`define EBP_ASSIGN_RW_EN 2
`define EBP_MODE_SEL_HI 7
`define EBP_MODE_SEL_LO 5
`define EBP_MODE_VIS 3
`define EBP_MODE_PORT_K_EN 0
`define EBP_BIC_STRETCH 0
`define EBP_IRQ_EDGE 7
`define EBP_IRQ_EN 6

// Port E and port K pin positions
`define EBP_PE_BCLK 4
`define EBP_PE_LOW_BYTE_STROBE_N 3
`define EBP_PE_RW 2
`define EBP_PE_IRQ 1
`define EBP_PE_NMI 0
`define EBP_PK_EMUL 7
`define EBP_PK_XDATA 6

// Operating mode codes
`define EBP_MD_SPECIAL_SINGLE 3'h0
`define EBP_MD_EMUL_NARROW 3'h1
`define EBP_MD_SPECIAL_TEST 3'h2
`define EBP_MD_EMUL_WIDE 3'h3
`define EBP_MD_NORMAL_SINGLE 3'h4
`define EBP_MD_NORMAL_NARROW 3'h5
`define EBP_MD_PERIPHERAL 3'h6
`define EBP_MD_NORMAL_WIDE 3'h7

// Timing
`define EBP_CLK_MHZ 200
`define EBP_STRETCH_NS 10
`define EBP_STRETCH_CYC ((`EBP_STRETCH_NS * `EBP_CLK_MHZ + 999) / 1000)

`endif

// ### rtl/ebp_pkg.sv
package ebp_pkg;

   // One external access request from the CPU side
   typedef struct packed {
      logic valid;
      logic internal;
      logic slow;
      logic write;
      logic low_byte;
      logic emul;
      logic ext_data;
      logic [5:0] page;
   } ebp_acc_t;

   // Bus timing clock sequencer
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_LOW = 4'b0010,
      ST_HIGH = 4'b0100,
      ST_STRETCH = 4'b1000
   } ebp_state_t;

endpackage

// ### tb/ebp_bus_port_asserts.sv
`timescale 1ns/1ps
module ebp_bus_port_asserts (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register port
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Access side
   input wire ebp_pkg::ebp_acc_t acc,
   input wire logic acc_busy,
   input wire logic tester_narrow,
   input wire logic tester_read,
   input wire logic tag_low_hit,
   input wire logic nonmaskable_irq,
   // Port E pins
   input wire logic [7:0] pe_in,
   input wire logic [7:0] pe_oe_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Read data only shows in the cycle after a read
   rdata_slot_a: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
      else $error("read data outside read slot");
   // An idle sequencer takes a request at once
   busy_start_a: assert property (acc.valid && !acc_busy |=> acc_busy)
      else $error("access not taken");
   // Fast access is exactly one low and one high phase
   fast_len_a: assert property (acc.valid && !acc_busy && !acc.slow |=>
      acc_busy[*2] ##1 !acc_busy) else $error("fast access length wrong");
   // Slow access is two or four cycles, by stretch setting
   slow_len_a: assert property (acc.valid && !acc_busy && acc.slow |=>
      acc_busy[*2] ##1 (!acc_busy or (acc_busy[*2] ##1 !acc_busy)))
      else $error("slow access length wrong");
   // Tester owns direction and size pins when it reports them
   rw_input_a: assert property (tester_read |-> pe_oe_n[2])
      else $error("direction pin driven in tester mode");
   size_input_a: assert property (tester_narrow |-> pe_oe_n[3])
      else $error("size pin driven in tester mode");
   // Interrupt pins are never driven
   irq_input_a: assert property (pe_oe_n[1:0] == 2'b11)
      else $error("interrupt pin driven");
   // Tag is a single pulse per bus clock fall
   tag_pulse_a: assert property (tag_low_hit |=> !tag_low_hit)
      else $error("tag pulse too long");
   // Non-maskable request follows a settled pin
   nmi_set_a: assert property ((!pe_in[0])[*8] |-> nonmaskable_irq)
      else $error("non-maskable request missed");
   nmi_clr_a: assert property (pe_in[0][*8] |-> !nonmaskable_irq)
      else $error("non-maskable request stuck");
endmodule

bind ebp_bus_port ebp_bus_port_asserts u_asserts (.clk, .rst_n, .reg_rd, .reg_rdata, .acc,
   .acc_busy, .tester_narrow, .tester_read, .tag_low_hit, .nonmaskable_irq, .pe_in, .pe_oe_n);

// ### tb/ebp_far_end.sv
`timescale 1ns/1ps
module ebp_far_end (
   // Clocks
   input wire logic clk,
   input wire logic link_clk,
   // Scenario controls
   input wire logic periph,
   input wire logic narrow,
   input wire logic rd_t,
   input wire logic tag_n,
   input wire logic [1:0] irq_n,
   // Pins
   input wire logic [7:0] pe_out,
   input wire logic [7:0] pe_oe_n,
   input wire logic [7:0] pk_out,
   input wire logic [7:0] pk_oe_n,
   output logic [7:0] pe_in,
   output logic [7:0] pk_in
);
   logic [1:0] tst_r;
   logic [2:0] ctl_r;
   wire [7:0] ext_w;

   // Tester moves size and direction only on its own clock
   always @(posedge link_clk) begin
      tst_r <= {narrow, rd_t};
   end

   // Interrupt and tag lines follow the system clock
   always @(posedge clk) begin
      ctl_r <= {tag_n, irq_n};
   end

   // Released pins float high on pull-ups; tester drives only in its mode
   assign ext_w = {4'hf, periph ? tst_r : 2'b11, ctl_r[1:0]};
   // Tag pulls the strobe line low over whatever drives it
   assign pe_in = ((pe_out & ~pe_oe_n) | (ext_w & pe_oe_n)) & {4'hf, ctl_r[2], 3'h7};
   assign pk_in = pk_out | pk_oe_n;
endmodule

// ### tb/external_bus_pin_and_map_bench.sv
`timescale 1ns/1ps
module external_bus_pin_and_map_bench;
   logic clk = 1'b0;
   logic link_clk = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [9:0] reg_addr = 10'h000;
   logic [7:0] reg_wdata = 8'h00;
   logic tag_enable = 1'b0;
   logic irq_edge_ack = 1'b0;
   logic periph = 1'b0;
   logic narrow = 1'b0;
   logic rd_t = 1'b0;
   logic tag_n = 1'b1;
   logic [1:0] irq_n = 2'b11;
   logic [2:0] strap = 3'h2;
   ebp_pkg::ebp_acc_t acc = '0;
   logic [7:0] reg_rdata, pe_in, pe_out, pe_oe_n, pk_in, pk_out, pk_oe_n;
   logic acc_busy, maskable_irq, nonmaskable_irq, tag_low_hit, tester_narrow, tester_read;
   logic prev;
   int num_errors = 0;
   int comparisons = 0;
   logic [5:0] ofs [16] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h07, 6'h09, 6'h0a,
      6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f, 6'h1e, 6'h33, 6'h3f};
   logic [7:0] msk [16] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'hfc, 8'h1c,
      8'he9, 8'hff, 8'hff, 8'h01, 8'h00, 8'hc0, 8'hff, 8'h00};

   ebp_bus_port dut (.clk, .rst_n, .link_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .acc, .tag_enable, .irq_edge_ack, .acc_busy, .maskable_irq, .nonmaskable_irq,
      .tag_low_hit, .tester_narrow, .tester_read, .mode_strap(strap), .pe_in, .pe_out,
      .pe_oe_n, .pk_in, .pk_out, .pk_oe_n);
   ebp_far_end far (.clk, .link_clk, .periph, .narrow, .rd_t, .tag_n, .irq_n, .pe_out,
      .pe_oe_n, .pk_out, .pk_oe_n, .pe_in, .pk_in);

   // System clock, and a link clock of unrelated phase
   initial forever #2.5 clk = ~clk;
   initial begin
      #31;
      forever #62.5 link_clk = ~link_clk;
   end

   // Comparisons for bytes and for single bits
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk1(string n, logic e, logic g);
      chk(n, {7'h00, e}, {7'h00, g});
   endtask

   // Register bus cycles; release lands at the edge, next request 1 ns later
   task automatic wr(logic [9:0] a, logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(logic [9:0] a, logic [7:0] m, logic [7:0] e, string n);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(n, e, reg_rdata & m);
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic cfg(logic [7:0] m, logic [7:0] a, logic [7:0] s);
      wr(10'h00b, m);
      wr(10'h00a, a);
      wr(10'h00e, s);
   endtask

   // One access; counts busy and bus clock high cycles, checks pins mid-access
   task automatic access(logic slow, logic em, int nb, int nh);
      int b;
      int h;
      b = 0;
      h = 0;
      acc <= {2'b10, slow, 2'b11, em, ~em, 6'h2a};
      @(posedge clk);
      acc.valid <= 1'b0;
      for (int i = 0; i < 10; i++) begin
         #1;
         b += acc_busy;
         h += pe_out[4];
         if (i == 1) begin
            chk1("strobe", 1'b0, pe_out[3]);
            chk1("rw", 1'b0, pe_out[2]);
            chk1("emul sel", ~em, pk_out[7]);
            chk1("data sel", em, pk_out[6]);
            chk("page", 8'h2a, {2'b00, pk_out[5:0]});
         end
         @(posedge clk);
      end
      chk("busy", 8'(nb), 8'(b));
      chk("clock high", 8'(nh), 8'(h));
   endtask

   // Counts tag pulses over a window
   task automatic tags(logic e);
      int n;
      n = 0;
      repeat (16) begin
         tick(1);
         n += tag_low_hit;
      end
      chk1("tag", e, n > 0);
   endtask

   task automatic end_sim;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Watchdog, well beyond the few hundred cycles the tests need
   initial begin
      #50000;
      num_errors++;
      end_sim;
   end

   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      tick(4);
      // Reset values, unmapped offsets included
      for (int i = 0; i < 64; i++) begin
         if (i != 8 && i != 50) begin
            rd(10'(i), 8'hff, (i == 11) ? 8'h40 : 8'h00, "reset");
         end
      end
      // Readback with junk in the upper address bits
      for (int i = 0; i < 16; i++) begin
         wr({4'hf, ofs[i]}, 8'hff);
         rd({4'h5, ofs[i]}, 8'hff, msk[i], "readback");
      end
      // Free-running bus clock toggles every cycle
      cfg(8'he1, 8'h0c, 8'h00);
      tick(2);
      for (int i = 0; i < 4; i++) begin
         prev = pe_out[4];
         tick(1);
         chk1("free clock", ~prev, pe_out[4]);
      end
      // Pulse mode with stretch
      wr(10'h00e, 8'h01);
      access(1'b0, 1'b0, 2, 1);
      access(1'b1, 1'b1, 4, 3);
      // Internal access with visibility off keeps the clock pin low
      prev = 1'b0;
      acc <= {2'b11, 5'h00, 6'h00};
      @(posedge clk);
      acc.valid <= 1'b0;
      repeat (4) begin
         #1;
         prev |= pe_out[4];
         @(posedge clk);
      end
      chk1("hidden clock", 1'b0, prev);
      // Clock pin handed back to general use
      cfg(8'he1, 8'h1c, 8'h00);
      wr(10'h009, 8'h10);
      wr(10'h008, 8'h10);
      tick(2);
      chk1("clock gpio", 1'b1, pe_out[4]);
      chk1("clock oe", 1'b0, pe_oe_n[4]);
      tick(1);
      chk1("clock gpio", 1'b1, pe_out[4]);
      // Tester mode: size and direction come in over the link
      narrow <= 1'b1;
      rd_t <= 1'b1;
      periph <= 1'b1;
      wr(10'h00b, 8'hc0);
      tick(120);
      chk1("size in", 1'b1, tester_narrow);
      chk1("dir in", 1'b1, tester_read);
      chk1("dir oe", 1'b1, pe_oe_n[2]);
      narrow <= 1'b0;
      tick(120);
      chk1("size in", 1'b0, tester_narrow);
      periph <= 1'b0;
      cfg(8'he1, 8'h0c, 8'h00);
      tick(8);
      chk1("dir oe", 1'b0, pe_oe_n[2]);
      chk1("dir in", 1'b0, tester_read);
      // Tagging: only with tag enabled and pin low
      tag_enable <= 1'b1;
      tag_n <= 1'b0;
      tags(1'b1);
      tag_n <= 1'b1;
      tick(6);
      tags(1'b0);
      tag_n <= 1'b0;
      tag_enable <= 1'b0;
      tick(6);
      tags(1'b0);
      tag_n <= 1'b1;
      // Maskable request: level, edge with acknowledge, masked
      wr(10'h01e, 8'h40);
      irq_n <= 2'b01;
      tick(6);
      chk1("level irq", 1'b1, maskable_irq);
      rd(10'h008, 8'h03, 8'h01, "pin read");
      irq_n <= 2'b11;
      tick(6);
      chk1("level irq", 1'b0, maskable_irq);
      wr(10'h01e, 8'hc0);
      // Clear the edge latched during the level test, so the next edge is real
      irq_edge_ack <= 1'b1;
      tick(1);
      irq_edge_ack <= 1'b0;
      tick(2);
      chk1("edge idle", 1'b0, maskable_irq);
      irq_n <= 2'b01;
      tick(6);
      irq_n <= 2'b11;
      tick(6);
      chk1("edge irq", 1'b1, maskable_irq);
      irq_edge_ack <= 1'b1;
      @(posedge clk);
      irq_edge_ack <= 1'b0;
      tick(2);
      chk1("edge ack", 1'b0, maskable_irq);
      wr(10'h01e, 8'h80);
      irq_n <= 2'b01;
      tick(6);
      chk1("masked irq", 1'b0, maskable_irq);
      irq_n <= 2'b10;
      tick(6);
      chk1("nmi", 1'b1, nonmaskable_irq);
      irq_n <= 2'b11;
      tick(6);
      chk1("nmi", 1'b0, nonmaskable_irq);
      // Port K as plain I/O when bus functions are off
      wr(10'h00b, 8'he0);
      wr(10'h033, 8'hff);
      wr(10'h032, 8'ha5);
      tick(2);
      chk("port k out", 8'ha5, pk_out);
      chk("port k oe", 8'h00, pk_oe_n);
      rd(10'h032, 8'hff, 8'ha5, "port k data");
      wr(10'h033, 8'h00);
      tick(2);
      chk("port k oe", 8'hff, pk_oe_n);
      // Mid-run reset with a peripheral strap; mode follows the new strap
      strap <= 3'h6;
      rst_n <= 1'b0;
      tick(3);
      rst_n <= 1'b1;
      tick(4);
      rd(10'h00b, 8'hff, 8'hc0, "strap mode");
      rd(10'h033, 8'hff, 8'h00, "reset again");
      end_sim;
   end
endmodule
